/* verilog/fcs_core.sv */
// flash configuration loader and in-application flash service engine
// assumes a flash port with one-cycle-or-later read data and an
// array controller that runs erase and CRC jobs and reports done
`default_nettype none

module fcs_core
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // service call from the core
  input wire logic call_valid,
  output logic call_ready,
  input wire logic [7:0] call_code,
  input wire logic [7:0] call_addr_high,
  input wire logic [7:0] call_addr_low,
  input wire logic [7:0] call_arg,
  input wire logic irq_pending,
  // service result
  output logic result_valid,
  output logic [7:0] result_byte3,
  output logic [7:0] result_byte2,
  output logic [7:0] result_byte1,
  output logic [7:0] result_byte0,
  output logic result_carry,
  // flash read port
  output logic flash_rd,
  output logic [15:0] flash_addr,
  output logic flash_cfg_space,
  input wire logic flash_rd_done,
  input wire logic [7:0] flash_rd_data,
  // flash array job port
  output logic job_start,
  output logic job_abort,
  output logic job_erase_page,
  output logic job_erase_sector,
  output logic job_crc_sector,
  output logic job_crc_global,
  input wire logic job_done,
  input wire logic [31:0] job_crc,
  input wire logic [3:0] job_err,
  // misc bytes held elsewhere
  input wire logic [7:0] boot_vector,
  input wire logic [7:0] boot_status,
  input wire logic [63:0] security_bytes,
  // config outputs
  output logic internal_reset_b,
  output logic [OSC_SEL_W-1:0] osc_select,
  output logic osc_code_reserved,
  output logic shared_reset_pin_is_reset,
  output logic watchdog_reset_enable,
  output logic watchdog_safety_enable,
  output logic brownout_config_low,
  output logic brownout_config_high,
  output logic rc_frequency_doubler,
  // shared pin and watchdog
  input wire logic shared_reset_pin,
  input wire logic watchdog_timeout,
  output logic shared_pin_reset_req,
  output logic watchdog_reset_req,
  output logic shared_pin_gp_in
);
  typedef enum logic [2:0] {
    FCS_LOAD1 = 3'b000,
    FCS_LOAD2 = 3'b001,
    FCS_IDLE = 3'b011,
    FCS_READ = 3'b010,
    FCS_JOB = 3'b110,
    FCS_DONE = 3'b111
  } fcs_state_t;

  fcs_state_t state, next_state;
  logic [7:0] power_up_config_byte1, next_cfg1;
  logic [7:0] power_up_config_byte2, next_cfg2;
  logic [7:0] code, next_code;
  logic [31:0] res, next_res;
  logic carry, next_carry;
  logic powered, next_powered;

  // misc address decode, used for lookup and for error check
  function automatic logic misc_ok(input logic [7:0] a);
    if (a <= MISC_STATUS) begin
      misc_ok = 1'b1;
    end else if (a >= MISC_SEC_FIRST && a <= MISC_SEC_LAST) begin
      misc_ok = 1'b1;
    end else begin
      misc_ok = 1'b0;
    end
  endfunction : misc_ok

  function automatic logic [7:0] misc_byte(input logic [7:0] a,
      input logic [7:0] c1, input logic [7:0] c2,
      input logic [7:0] bv, input logic [7:0] bs,
      input logic [63:0] sec);
    if (a == MISC_CFG1) begin
      misc_byte = c1;
    end else if (a == MISC_CFG2) begin
      misc_byte = c2;
    end else if (a == MISC_BOOT_VECTOR) begin
      misc_byte = bv;
    end else if (a == MISC_STATUS) begin
      misc_byte = bs;
    end else if (a >= MISC_SEC_FIRST && a <= MISC_SEC_LAST) begin
      misc_byte = sec[8*a[2:0] +: 8];
    end else begin
      misc_byte = 8'h00;
    end
  endfunction : misc_byte

  // lower four status bits only; upper bits stay zero
  logic [7:0] err_status;
  assign err_status = {4'h0, job_err};

  always_comb begin
    next_state = state;
    next_cfg1 = power_up_config_byte1;
    next_cfg2 = power_up_config_byte2;
    next_code = code;
    next_res = res;
    next_carry = carry;
    next_powered = powered;
    case (state)
      FCS_LOAD1: begin
        if (flash_rd_done) begin
          next_cfg1 = flash_rd_data;
          next_state = FCS_LOAD2;
        end
      end
      FCS_LOAD2: begin
        if (flash_rd_done) begin
          next_cfg2 = flash_rd_data;
          next_powered = 1'b1;
          next_state = FCS_IDLE;
        end
      end
      FCS_IDLE: begin
        if (call_valid) begin
          next_code = call_code;
          next_res = '0;
          next_carry = 1'b0;
          if (call_code == CMD_MISC_READ) begin
            if (misc_ok(call_arg)) begin
              next_res[7:0] = misc_byte(call_arg, power_up_config_byte1,
                  power_up_config_byte2, boot_vector, boot_status,
                  security_bytes);
            end else begin
              next_carry = 1'b1;
              next_res[7:0] = 8'h00;
            end
            next_state = FCS_DONE;
          end else if (call_code == CMD_USER_READ) begin
            next_state = FCS_READ;
          end else if (call_code == CMD_ERASE) begin
            if (call_arg == ERASE_PAGE_SEL ||
                call_arg == ERASE_SECTOR_SEL) begin
              next_state = FCS_JOB;
            end else begin
              next_carry = 1'b1;
              next_state = FCS_DONE;
            end
          end else if (call_code == CMD_SECTOR_CRC ||
              call_code == CMD_GLOBAL_CRC) begin
            next_state = FCS_JOB;
          end else begin
            next_carry = 1'b1;
            next_state = FCS_DONE;
          end
        end
      end
      FCS_READ: begin
        if (flash_rd_done) begin
          next_res[7:0] = flash_rd_data;
          next_state = FCS_DONE;
        end
      end
      FCS_JOB: begin
        if (irq_pending) begin
          // abort so the flash can fetch the interrupt handler
          next_carry = 1'b1;
          next_res[7:0] = 8'h01 << ERR_INTERRUPTED;
          next_state = FCS_DONE;
        end else if (job_done) begin
          if (code == CMD_SECTOR_CRC || code == CMD_GLOBAL_CRC) begin
            next_res = job_crc;
          end
          if (job_err != 4'h0) begin
            next_carry = 1'b1;
            next_res[7:0] = err_status;
          end
          next_state = FCS_DONE;
        end
      end
      FCS_DONE: begin
        next_state = FCS_IDLE;
      end
      default: begin
        next_state = FCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FCS_LOAD1;
      power_up_config_byte1 <= CFG1_RESET_VALUE;
      power_up_config_byte2 <= CFG2_RESET_VALUE;
      code <= 8'h00;
      res <= '0;
      carry <= 1'b0;
      powered <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      // no write path: only the power-up load changes these
      power_up_config_byte1 <= next_cfg1;
      power_up_config_byte2 <= next_cfg2;
      code <= next_code;
      res <= next_res;
      carry <= next_carry;
      powered <= next_powered;
    end
  end

  // handshake and flash ports
  assign call_ready = clk_en && (state == FCS_IDLE);
  assign result_valid = clk_en && (state == FCS_DONE);
  assign result_byte3 = res[31:24];
  assign result_byte2 = res[23:16];
  assign result_byte1 = res[15:8];
  assign result_byte0 = res[7:0];
  assign result_carry = carry;
  assign flash_rd = clk_en && (state == FCS_LOAD1 || state == FCS_LOAD2 ||
      state == FCS_READ);
  assign flash_cfg_space = (state == FCS_LOAD1) || (state == FCS_LOAD2);
  always_comb begin
    if (state == FCS_LOAD1) begin
      flash_addr = CFG1_FLASH_ADDR;
    end else if (state == FCS_LOAD2) begin
      flash_addr = CFG2_FLASH_ADDR;
    end else begin
      flash_addr = {call_addr_high, call_addr_low};
    end
  end
  assign job_start = clk_en && (state == FCS_IDLE) && call_valid &&
      (next_state == FCS_JOB);
  assign job_abort = clk_en && (state == FCS_JOB) && irq_pending;
  // kind flags follow the live code in the start cycle, not a stale one
  logic [7:0] job_code;
  assign job_code = (state == FCS_IDLE) ? call_code : code;
  assign job_erase_page = (job_code == CMD_ERASE) &&
      (call_arg == ERASE_PAGE_SEL);
  assign job_erase_sector = (job_code == CMD_ERASE) &&
      (call_arg == ERASE_SECTOR_SEL);
  assign job_crc_sector = (job_code == CMD_SECTOR_CRC);
  assign job_crc_global = (job_code == CMD_GLOBAL_CRC);

  // configuration outputs from held copies
  assign internal_reset_b = powered;
  assign shared_reset_pin_is_reset = !powered ||
      power_up_config_byte1[CFG1_RESET_PIN];
  assign shared_pin_reset_req = shared_reset_pin_is_reset &&
      !shared_reset_pin;
  assign shared_pin_gp_in = shared_reset_pin_is_reset ? 1'b1 :
      shared_reset_pin;
  assign watchdog_reset_enable = power_up_config_byte1[CFG1_WD_RESET];
  assign watchdog_reset_req = watchdog_timeout &&
      watchdog_reset_enable;
  assign watchdog_safety_enable = power_up_config_byte1[CFG1_WD_SAFETY];
  assign brownout_config_low = power_up_config_byte1[CFG1_BROWNOUT_LOW];
  assign brownout_config_high =
      power_up_config_byte1[CFG1_BROWNOUT_HIGH];
  assign rc_frequency_doubler = power_up_config_byte2[CFG2_DOUBLER];

  fcs_osc_decode fcs_osc_decode_inst (
    .osc_code(power_up_config_byte1[CFG1_OSC_LSB +: 3]),
    .osc_select(osc_select),
    .osc_code_reserved(osc_code_reserved)
  );

  a_misc_cfg1: assert property (
      @(posedge clk) disable iff (!rst_b)
      clk_en && state == FCS_IDLE && call_valid &&
      call_code == CMD_MISC_READ && call_arg == MISC_CFG1
      |=> result_byte0 == $past(power_up_config_byte1) && !result_carry)
    else $error("misc read of cfg1 wrong");
  a_bad_misc_carry: assert property (
      @(posedge clk) disable iff (!rst_b)
      clk_en && state == FCS_IDLE && call_valid &&
      call_code == CMD_MISC_READ && call_arg == 8'h05
      |=> result_valid && result_carry)
    else $error("reserved misc address not flagged");
  a_irq_abort: assert property (
      @(posedge clk) disable iff (!rst_b)
      clk_en && state == FCS_JOB && irq_pending
      |=> result_valid && result_carry && result_byte0 == 8'h01)
    else $error("interrupt did not abort job");
  a_crc_order: assert property (
      @(posedge clk) disable iff (!rst_b)
      clk_en && state == FCS_JOB && !irq_pending && job_done &&
      job_err == 4'h0 && (code == CMD_SECTOR_CRC || code == CMD_GLOBAL_CRC)
      |=> {result_byte3, result_byte2, result_byte1, result_byte0} ==
      $past(job_crc))
    else $error("crc byte order wrong");
  a_err_low_byte: assert property (
      @(posedge clk) disable iff (!rst_b)
      clk_en && state == FCS_JOB && !irq_pending && job_done &&
      job_err != 4'h0 |=> result_carry &&
      result_byte0 == {4'h0, $past(job_err)})
    else $error("error status not in low byte");
  a_cfg_frozen: assert property (
      @(posedge clk) disable iff (!rst_b)
      powered |=> $stable(power_up_config_byte1) &&
      $stable(power_up_config_byte2))
    else $error("config changed after power-up");
  a_pin_powerup: assert property (
      @(posedge clk) disable iff (!rst_b)
      !powered && !shared_reset_pin |-> shared_pin_reset_req)
    else $error("pin not reset during power-up");
  a_wd_gate: assert property (
      @(posedge clk) disable iff (!rst_b)
      watchdog_timeout && !power_up_config_byte1[CFG1_WD_RESET]
      |-> !watchdog_reset_req)
    else $error("watchdog reset while disabled");
endmodule : fcs_core

`default_nettype wire

/* verilog/fcs_pkg.sv */
// constants and types for the flash configuration and service block
// assumes a single 25 MHz clock and an active-low power-up reset
`default_nettype none

package fcs_pkg;
  // service call codes
  localparam logic [7:0] CMD_MISC_READ = 8'h03;
  localparam logic [7:0] CMD_ERASE = 8'h04;
  localparam logic [7:0] CMD_SECTOR_CRC = 8'h05;
  localparam logic [7:0] CMD_GLOBAL_CRC = 8'h06;
  localparam logic [7:0] CMD_USER_READ = 8'h07;
  // misc read addresses
  localparam logic [7:0] MISC_CFG1 = 8'h00;
  localparam logic [7:0] MISC_CFG2 = 8'h01;
  localparam logic [7:0] MISC_BOOT_VECTOR = 8'h02;
  localparam logic [7:0] MISC_STATUS = 8'h03;
  localparam logic [7:0] MISC_SEC_FIRST = 8'h08;
  localparam logic [7:0] MISC_SEC_LAST = 8'h0f;
  // erase selectors
  localparam logic [7:0] ERASE_PAGE_SEL = 8'h00;
  localparam logic [7:0] ERASE_SECTOR_SEL = 8'h01;
  // config byte 1 and 2 fields
  localparam int CFG1_OSC_LSB = 0;
  localparam int CFG1_BROWNOUT_LOW = 3;
  localparam int CFG1_WD_SAFETY = 4;
  localparam int CFG1_BROWNOUT_HIGH = 5;
  localparam int CFG1_RESET_PIN = 6;
  localparam int CFG1_WD_RESET = 7;
  localparam int CFG2_DOUBLER = 7;
  localparam logic [7:0] CFG1_RESET_VALUE = 8'h63;
  localparam logic [7:0] CFG2_RESET_VALUE = 8'h00;
  // flash addresses of the configuration bytes in the config space
  localparam logic [15:0] CFG1_FLASH_ADDR = 16'h0000;
  localparam logic [15:0] CFG2_FLASH_ADDR = 16'h0001;
  // error status bit positions
  localparam int ERR_INTERRUPTED = 0;
  localparam int ERR_SECURITY = 1;
  localparam int ERR_HIGH_VOLTAGE = 2;
  localparam int ERR_VERIFY = 3;
  // oscillator select codes
  typedef enum logic [2:0] {
    FCS_OSC_HIGH_XTAL = 3'h0,
    FCS_OSC_MED_XTAL = 3'h1,
    FCS_OSC_LOW_XTAL = 3'h2,
    FCS_OSC_INT_RC = 3'h3,
    FCS_OSC_WATCHDOG = 3'h4,
    FCS_OSC_EXT_CLOCK = 3'h7
  } fcs_osc_t;
  // one-hot decoded clock source
  localparam int OSC_SEL_W = 6;
endpackage : fcs_pkg

`default_nettype wire

/* verilog/fcs_osc_decode.sv */
// oscillator select decoder
// assumes a power-up held config byte at its input
`default_nettype none

module fcs_osc_decode
  import fcs_pkg::*;
(
  // held field
  input wire logic [2:0] osc_code,
  // decoded source, one-hot
  output logic [OSC_SEL_W-1:0] osc_select,
  output logic osc_code_reserved
);
  always_comb begin
    osc_select = '0;
    osc_code_reserved = 1'b0;
    case (osc_code)
      FCS_OSC_HIGH_XTAL: osc_select[0] = 1'b1;
      FCS_OSC_MED_XTAL: osc_select[1] = 1'b1;
      FCS_OSC_LOW_XTAL: osc_select[2] = 1'b1;
      FCS_OSC_INT_RC: osc_select[3] = 1'b1;
      FCS_OSC_WATCHDOG: osc_select[4] = 1'b1;
      FCS_OSC_EXT_CLOCK: osc_select[5] = 1'b1;
      // reserved codes pick nothing; software must avoid them
      default: osc_code_reserved = 1'b1;
    endcase
  end
endmodule : fcs_osc_decode

`default_nettype wire

/* tb/fcs_flash_model.sv */
// flash array stand-in: config image reads and self-timed jobs
// assumes the block's flash read and job ports on one clock
`default_nettype none

module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [31:0] CRC_VAL = 32'ha1b2c3d4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench knobs
  input wire logic [7:0] cfg1_img,
  input wire logic [7:0] cfg2_img,
  input wire logic [3:0] lat,
  input wire logic [3:0] err_inject,
  // flash read port
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic flash_cfg_space,
  output logic flash_rd_done,
  output logic [7:0] flash_rd_data,
  // job port
  input wire logic job_start,
  input wire logic job_abort,
  output logic job_done,
  output logic [31:0] job_crc,
  output logic [3:0] job_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rd_cnt;
  logic [3:0] job_cnt;
  logic busy;
  logic [7:0] rd_val;
  assign rd_val = flash_cfg_space ? (flash_addr[0] ? cfg2_img : cfg1_img)
                                  : flash_addr[15:8] ^ flash_addr[7:0];
  // idle read data and CRC lines show the inverse so a stale value never matches; idle job_err reads zero
  assign flash_rd_data = flash_rd_done ? rd_val : ~rd_val;
  assign job_crc = job_done ? CRC_VAL : ~CRC_VAL;
  assign job_err = job_done ? err_inject : 4'h0;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_cnt <= 4'h0;
      flash_rd_done <= 1'b0;
      job_cnt <= 4'h0;
      busy <= 1'b0;
      job_done <= 1'b0;
    end else begin
      flash_rd_done <= 1'b0;
      job_done <= 1'b0;
      if (flash_rd && !flash_rd_done) begin
        rd_cnt <= rd_cnt + 4'h1;
        if (rd_cnt == lat) begin
          rd_cnt <= 4'h0;
          flash_rd_done <= 1'b1;
        end
      end
      if (job_start) begin
        busy <= 1'b1;
        job_cnt <= 4'h0;
      end else if (busy && job_abort) begin
        busy <= 1'b0;
      end else if (busy && job_cnt == lat) begin
        busy <= 1'b0;
        job_done <= 1'b1;
      end else begin
        job_cnt <= job_cnt + 4'h1;
      end
    end
  end
endmodule : fcs_flash_model

`default_nettype wire

/* tb/fcs_core_bench.sv */
// self-checking bench for the config loader and service engine
// assumes fcs_core and the flash stand-in on one 25 MHz clock
`default_nettype none

module fcs_core_bench
  import fcs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CRC_VAL = 32'ha1b2c3d4;
  localparam logic [7:0] BV = 8'h1f;
  localparam logic [7:0] BS = 8'h01;
  localparam logic [63:0] SEC = 64'h8877665544332211;
  logic clk = 1'b0, rst_b = 1'b0, call_valid = 1'b0, irq_pending = 1'b0;
  logic clk_en = 1'b1, saw_cs, saw_cg;
  logic [7:0] call_code = 8'h00, call_addr_high = 8'h00;
  logic [7:0] call_addr_low = 8'h00, call_arg = 8'h00;
  logic [7:0] cfg1_img = 8'h63, cfg2_img = 8'h00, e;
  logic [3:0] lat = 4'h1, err_inject = 4'h0;
  logic shared_reset_pin = 1'b0, watchdog_timeout = 1'b1;
  logic call_ready, result_valid, result_carry, flash_rd, flash_cfg_space;
  logic [7:0] result_byte3, result_byte2, result_byte1, result_byte0;
  logic flash_rd_done, job_start, job_abort, job_erase_page;
  logic job_erase_sector, job_crc_sector, job_crc_global, job_done;
  logic [15:0] flash_addr;
  logic [7:0] flash_rd_data;
  logic [31:0] job_crc, res;
  logic [3:0] job_err;
  logic [OSC_SEL_W-1:0] osc_select;
  logic internal_reset_b, osc_code_reserved, shared_reset_pin_is_reset;
  logic watchdog_reset_enable, watchdog_safety_enable, brownout_config_low;
  logic brownout_config_high, rc_frequency_doubler, shared_pin_reset_req;
  logic watchdog_reset_req, shared_pin_gp_in, cy, saw_pg, saw_sec;
  logic [7:0] imgs [6] = '{8'h98, 8'h41, 8'he2, 8'h63, 8'h3c, 8'h87};
  int err_total = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  fcs_core fcs_core_inst (.clk, .rst_b, .clk_en, .call_valid,
    .call_ready, .call_code, .call_addr_high, .call_addr_low, .call_arg,
    .irq_pending, .result_valid, .result_byte3, .result_byte2,
    .result_byte1, .result_byte0, .result_carry, .flash_rd, .flash_addr,
    .flash_cfg_space, .flash_rd_done, .flash_rd_data, .job_start,
    .job_abort, .job_erase_page, .job_erase_sector, .job_crc_sector,
    .job_crc_global, .job_done, .job_crc, .job_err, .boot_vector(BV),
    .boot_status(BS), .security_bytes(SEC), .internal_reset_b, .osc_select,
    .osc_code_reserved, .shared_reset_pin_is_reset, .watchdog_reset_enable,
    .watchdog_safety_enable, .brownout_config_low, .brownout_config_high,
    .rc_frequency_doubler, .shared_reset_pin, .watchdog_timeout,
    .shared_pin_reset_req, .watchdog_reset_req, .shared_pin_gp_in);

  fcs_flash_model #(.CRC_VAL(CRC_VAL)) fcs_flash_model_inst (.clk, .rst_b,
    .cfg1_img, .cfg2_img, .lat, .err_inject, .flash_rd, .flash_addr,
    .flash_cfg_space, .flash_rd_done, .flash_rd_data, .job_start,
    .job_abort, .job_done, .job_crc, .job_err);

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic pwr_up(input logic [7:0] c1, input logic [7:0] c2);
    @(posedge clk);
    #1 rst_b = 1'b0;
    cfg1_img = c1;
    cfg2_img = c2;
    repeat (20) @(negedge clk);
    chk(internal_reset_b, 1'b0);
    chk(shared_reset_pin_is_reset, 1'b1);
    @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (40) begin
      @(negedge clk);
      if (internal_reset_b === 1'b1) break;
    end
    chk(internal_reset_b, 1'b1);
  endtask : pwr_up

  task automatic chk_cfg(input logic [7:0] c1, input logic [7:0] c2);
    @(negedge clk);
    chk(osc_select, c1[2:0] == 3'h7 ? 6'h20 : 6'h01 << c1[2:0]);
    chk(osc_code_reserved, 1'b0);
    chk(shared_reset_pin_is_reset, c1[6]);
    chk(shared_pin_reset_req, c1[6]);
    chk(shared_pin_gp_in, c1[6]);
    chk(watchdog_reset_enable, c1[7]);
    chk(watchdog_reset_req, c1[7]);
    chk(watchdog_safety_enable, c1[4]);
    chk({brownout_config_high, brownout_config_low}, {c1[5], c1[3]});
    chk(rc_frequency_doubler, c2[7]);
    // released pin and quiet watchdog raise no reset request
    @(posedge clk);
    #1 shared_reset_pin = 1'b1;
    watchdog_timeout = 1'b0;
    @(negedge clk);
    chk({shared_pin_reset_req, shared_pin_gp_in}, 2'b01);
    chk(watchdog_reset_req, 1'b0);
    @(posedge clk);
    #1 shared_reset_pin = 1'b0;
    watchdog_timeout = 1'b1;
  endtask : chk_cfg

  // one service call; arg stays put until the next call
  task automatic svc(input logic [7:0] code, input logic [7:0] hi,
                     input logic [7:0] lo, input logic [7:0] arg,
                     input logic irq);
    int n;
    @(posedge clk);
    #1;
    call_code = code;
    call_addr_high = hi;
    call_addr_low = lo;
    call_arg = arg;
    call_valid = 1'b1;
    do @(negedge clk); while (call_ready !== 1'b1);
    @(posedge clk);
    #1 call_valid = 1'b0;
    if (irq) begin
      repeat (2) @(posedge clk);
      #1 irq_pending = 1'b1;
    end
    n = 0;
    saw_pg = 1'b0;
    saw_sec = 1'b0;
    saw_cs = 1'b0;
    saw_cg = 1'b0;
    do begin
      @(negedge clk);
      saw_pg |= job_erase_page;
      saw_sec |= job_erase_sector;
      saw_cs |= job_crc_sector;
      saw_cg |= job_crc_global;
      n++;
    end while (result_valid !== 1'b1 && n < 100);
    chk(result_valid, 1'b1);
    res = {result_byte3, result_byte2, result_byte1, result_byte0};
    cy = result_carry;
    @(posedge clk);
    #1 irq_pending = 1'b0;
  endtask : svc

  initial begin
    for (int i = 0; i < 6; i++) begin
      pwr_up(imgs[i], {i[0], 7'h5a});
      chk_cfg(imgs[i], {i[0], 7'h5a});
      svc(CMD_MISC_READ, 8'h00, 8'h00, MISC_CFG2, 1'b0);
      chk(res[7:0], {i[0], 7'h5a});
    end
    cfg1_img = 8'h00;
    cfg2_img = 8'h00;
    repeat (3) @(posedge clk);
    chk_cfg(imgs[5], 8'hda);
    for (int a = 0; a < 17; a++) begin
      e = a < 2 ? (a == 1 ? 8'hda : imgs[5]) : a < 4 ? (a == 2 ? BV : BS)
        : (a > 7 && a < 16) ? SEC[8*(a-8) +: 8] : 8'h00;
      svc(CMD_MISC_READ, 8'h00, 8'h00, 8'(a), 1'b0);
      chk(res, {24'h0, e});
      chk(cy, (a > 3 && a < 8) || a == 16);
    end
    // frozen block neither answers nor takes a held request
    @(posedge clk);
    #1 clk_en = 1'b0;
    call_code = CMD_MISC_READ;
    call_arg = MISC_CFG1;
    call_valid = 1'b1;
    repeat (4) @(negedge clk);
    chk({result_valid, call_ready}, 2'b00);
    @(posedge clk);
    #1 clk_en = 1'b1;
    @(posedge clk);
    #1 call_valid = 1'b0;
    @(negedge clk);
    chk({result_valid, result_byte0}, {1'b1, imgs[5]});
    for (int k = 0; k < 2; k++) begin
      lat = 4'(k * 5);
      e = 8'(8'h3c + k);
      svc(CMD_USER_READ, 8'h5a, e, 8'h00, 1'b0);
      chk(res, {24'h0, 8'h5a ^ e});
      chk(cy, 1'b0);
    end
    lat = 4'h3;
    for (int s = 0; s < 3; s++) begin
      svc(CMD_ERASE, 8'h12, 8'h34, 8'(s), 1'b0);
      e = s == 0 ? 8'h02 : s == 1 ? 8'h01 : 8'h04;
      chk({cy, saw_pg, saw_sec}, e[2:0]);
    end
    svc(CMD_SECTOR_CRC, 8'h00, 8'h00, 8'h02, 1'b0);
    chk({cy, res}, {1'b0, CRC_VAL});
    chk({saw_cs, saw_cg}, 2'b10);
    err_inject = 4'h6;
    svc(CMD_GLOBAL_CRC, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({cy, res}, {1'b1, CRC_VAL[31:8], 8'h06});
    chk({saw_cs, saw_cg}, 2'b01);
    err_inject = 4'h0;
    lat = 4'h8;
    svc(CMD_GLOBAL_CRC, 8'h00, 8'h00, 8'h00, 1'b1);
    chk({cy, res[7:0]}, 9'h101);
    svc(8'h08, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({cy, res[7:0]}, 9'h100);
    report_and_stop();
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule : fcs_core_bench

`default_nettype wire
